// ---- bocfg_pkg.sv ----
// Package of constants for the board output and timebase configuration block
package bocfg_pkg;

  // ****************************************
  // Clock and timebase
  // ****************************************
  localparam int CLK_FREQ_HZ = 40_000_000;
  localparam int OSC_FREQ_HZ = 10_000_000;
  localparam int OSC_DIV_CYC = CLK_FREQ_HZ / OSC_FREQ_HZ;
  localparam int CTR_SRC_DIV = 10;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] REG_AO_CFG = 8'h00;
  localparam logic [7:0] REG_DIO_DIR = 8'h04;
  localparam logic [7:0] REG_CLK_CFG = 8'h08;
  localparam logic [7:0] REG_DAC0_CODE = 8'h0C;
  localparam logic [7:0] REG_DAC1_CODE = 8'h10;
  localparam logic [7:0] REG_DIO_DATA = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int AO_EXT_REF_BIT = 0;
  localparam int AO_BIPOLAR_BIT = 1;
  localparam int AO_CH_STRIDE = 2;
  localparam int DIO_A_OUT_BIT = 0;
  localparam int DIO_B_OUT_BIT = 1;
  localparam int CLK_BUS_SRC_BIT = 0;
  localparam int CLK_DRIVE_BIT = 1;
  localparam int DIO_A_LSB = 0;
  localparam int DIO_B_LSB = 4;
  localparam int ST_BUS_SRC_BIT = 0;
  localparam int ST_DRIVING_BIT = 1;
  localparam int ST_BUS_LVL_BIT = 2;
  localparam int ST_CTR_LVL_BIT = 3;

  // ****************************************
  // Widths and reset values
  // ****************************************
  localparam int DAC_W = 12;
  localparam int DIO_W = 4;
  localparam logic [3:0] AO_CFG_RST = 4'h0;
  localparam logic [1:0] DIO_DIR_RST = 2'h0;
  localparam logic [1:0] CLK_CFG_RST = 2'h0;
  localparam logic [11:0] DAC_CODE_RST = 12'h000;
  localparam logic [7:0] DIO_DATA_RST = 8'h00;

endpackage : bocfg_pkg

// ---- bocfg_divider.sv ----
// Enable-driven divider giving a tick pulse and a square level
`timescale 1ns/100ps
module bocfg_divider #(
  parameter int N = 10
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Input rate
  input wire logic en_i,
  // Divided rate
  output logic tick_o,
  output logic level_o
);
  localparam int W = (N > 1) ? $clog2(N) : 1;
  localparam logic [W-1:0] LAST = W'(N - 1);
  localparam logic [W-1:0] HALF = W'(N / 2);

  logic [W-1:0] count;

  // ****************************************
  // Counter
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= '0;
    end else if (en_i) begin
      count <= (count == LAST) ? '0 : W'(count + 1'b1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
      level_o <= 1'b0;
    end else begin
      tick_o <= en_i && (count == LAST);
      level_o <= (count < HALF);
    end
  end
endmodule : bocfg_divider

// ---- bocfg_dac_chan.sv ----
// One analog output channel: code interpretation and reference select
`timescale 1ns/100ps
module bocfg_dac_chan
  import bocfg_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Settings
  input wire logic [DAC_W-1:0] code_i,
  input wire logic bipolar_i,
  input wire logic ext_ref_i,
  // Converter side
  output logic [DAC_W-1:0] word_o,
  output logic signed [DAC_W:0] value_o,
  output logic bipolar_o,
  output logic ext_ref_o
);
  // ****************************************
  // Code interpretation
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      word_o <= '0;
      value_o <= '0;
      bipolar_o <= 1'b0;
      ext_ref_o <= 1'b0;
    end else begin
      if (bipolar_i) begin
        word_o <= {~code_i[DAC_W-1], code_i[DAC_W-2:0]}; // R3
        value_o <= {code_i[DAC_W-1], code_i}; // R3
      end else begin
        word_o <= code_i; // R4
        value_o <= {1'b0, code_i}; // R4
      end
      bipolar_o <= bipolar_i; // R2
      ext_ref_o <= ext_ref_i; // R1
    end
  end
endmodule : bocfg_dac_chan

// ---- bocfg_top.sv ----
// Board output and timebase configuration: register bank and timebase logic
//
// Operation
// R1: Each output channel selects internal 10 V or external reference independently.
// R2: Each output channel selects unipolar or bipolar independently.
// R3: Bipolar channel treats codes as two's complement, 800h to 7FFh.
// R4: Unipolar channel treats codes as straight binary, 000h to FFFh.
// R5: Eight digital lines form two four-bit ports.
// R6: Software sets each port's direction as a whole, independently.
// R7: Reset puts both digital ports into input direction.
// R8: Timebase comes from internal 10 MHz or the sync bus clock.
// R9: Drive own clock onto sync bus only if internal and drive set.
// R10: Selected timebase divided by 10 feeds the counter/timer source.
// R11: Reset default is internal timebase, bus driver off.
// R12: One board drives the bus clock; others receive or stay off.
// R13: Each channel holds a 12-bit code applied per current polarity.
// R14: Reset sets reference and polarity of both channels to defaults.
//
// Our own choices: the register addresses and the Wishbone register port.
`timescale 1ns/100ps
module bocfg_top
  import bocfg_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Analog output channel 0
  output logic [DAC_W-1:0] dac0_word_o,
  output logic signed [DAC_W:0] dac0_value_o,
  output logic dac0_bipolar_o,
  output logic dac0_ext_ref_o,
  // Analog output channel 1
  output logic [DAC_W-1:0] dac1_word_o,
  output logic signed [DAC_W:0] dac1_value_o,
  output logic dac1_bipolar_o,
  output logic dac1_ext_ref_o,
  // Digital port A
  input wire logic [DIO_W-1:0] dio_a_i,
  output logic [DIO_W-1:0] dio_a_o,
  output logic [DIO_W-1:0] dio_a_oe_o,
  // Digital port B
  input wire logic [DIO_W-1:0] dio_b_i,
  output logic [DIO_W-1:0] dio_b_o,
  output logic [DIO_W-1:0] dio_b_oe_o,
  // Synchronization bus clock line
  input wire logic board_sync_bus_clk_i,
  output logic board_sync_bus_clk_o,
  output logic board_sync_bus_clk_oe_o,
  // Counter/timer frequency source
  output logic ctr_src_tick_o,
  output logic ctr_src_clk_o
);

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] off);
    reg_hit = (adr[7:2] == off[7:2]);
  endfunction : reg_hit

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdat,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = wdat[8*i +: 8];
      end
    end
    merge = res;
  endfunction : merge

  // ****************************************
  // Registers
  // ****************************************
  logic [3:0] ao_cfg;
  logic [1:0] dio_dir;
  logic [1:0] clk_cfg;
  logic [DAC_W-1:0] dac_code [2];
  logic [7:0] dio_data;
  logic bus_req;
  logic wr_en;
  logic [31:0] next_rdata;

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_en = bus_req && wb_we_i;

  // ****************************************
  // Wishbone answer
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ao_cfg <= AO_CFG_RST; // R14
    end else if (wr_en && reg_hit(wb_adr_i, REG_AO_CFG)) begin
      ao_cfg <= 4'(merge({28'h0000000, ao_cfg}, wb_dat_i, wb_sel_i)); // R1
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dio_dir <= DIO_DIR_RST; // R7
    end else if (wr_en && reg_hit(wb_adr_i, REG_DIO_DIR)) begin
      dio_dir <= 2'(merge({30'h0, dio_dir}, wb_dat_i, wb_sel_i)); // R6
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_cfg <= CLK_CFG_RST; // R11
    end else if (wr_en && reg_hit(wb_adr_i, REG_CLK_CFG)) begin
      clk_cfg <= 2'(merge({30'h0, clk_cfg}, wb_dat_i, wb_sel_i)); // R8
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dac_code[0] <= DAC_CODE_RST;
      dac_code[1] <= DAC_CODE_RST;
    end else if (wr_en) begin
      if (reg_hit(wb_adr_i, REG_DAC0_CODE)) begin
        dac_code[0] <= DAC_W'(merge({20'h00000, dac_code[0]}, wb_dat_i, wb_sel_i)); // R13
      end
      if (reg_hit(wb_adr_i, REG_DAC1_CODE)) begin
        dac_code[1] <= DAC_W'(merge({20'h00000, dac_code[1]}, wb_dat_i, wb_sel_i)); // R13
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dio_data <= DIO_DATA_RST;
    end else if (wr_en && reg_hit(wb_adr_i, REG_DIO_DATA)) begin
      dio_data <= 8'(merge({24'h000000, dio_data}, wb_dat_i, wb_sel_i));
    end
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [DIO_W-1:0] dio_a_s1;
  logic [DIO_W-1:0] dio_a_s2;
  logic [DIO_W-1:0] dio_b_s1;
  logic [DIO_W-1:0] dio_b_s2;
  logic bus_s1;
  logic bus_s2;
  logic bus_s3;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dio_a_s1 <= '0;
      dio_a_s2 <= '0;
      dio_b_s1 <= '0;
      dio_b_s2 <= '0;
    end else begin
      dio_a_s1 <= dio_a_i;
      dio_a_s2 <= dio_a_s1;
      dio_b_s1 <= dio_b_i;
      dio_b_s2 <= dio_b_s1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_s1 <= 1'b0;
      bus_s2 <= 1'b0;
      bus_s3 <= 1'b0;
    end else begin
      bus_s1 <= board_sync_bus_clk_i;
      bus_s2 <= bus_s1;
      bus_s3 <= bus_s2;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always_comb begin
    next_rdata = 32'h00000000;
    if (reg_hit(wb_adr_i, REG_AO_CFG)) begin
      next_rdata[3:0] = ao_cfg;
    end else if (reg_hit(wb_adr_i, REG_DIO_DIR)) begin
      next_rdata[1:0] = dio_dir;
    end else if (reg_hit(wb_adr_i, REG_CLK_CFG)) begin
      next_rdata[1:0] = clk_cfg;
    end else if (reg_hit(wb_adr_i, REG_DAC0_CODE)) begin
      next_rdata[DAC_W-1:0] = dac_code[0];
    end else if (reg_hit(wb_adr_i, REG_DAC1_CODE)) begin
      next_rdata[DAC_W-1:0] = dac_code[1];
    end else if (reg_hit(wb_adr_i, REG_DIO_DATA)) begin
      next_rdata[DIO_A_LSB +: DIO_W] = dio_a_s2;
      next_rdata[DIO_B_LSB +: DIO_W] = dio_b_s2;
    end else if (reg_hit(wb_adr_i, REG_STATUS)) begin
      next_rdata[ST_BUS_SRC_BIT] = clk_cfg[CLK_BUS_SRC_BIT];
      next_rdata[ST_DRIVING_BIT] = board_sync_bus_clk_oe_o;
      next_rdata[ST_BUS_LVL_BIT] = bus_s2;
      next_rdata[ST_CTR_LVL_BIT] = ctr_src_clk_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (bus_req && !wb_we_i) begin
      wb_dat_o <= next_rdata;
    end
  end

  // ****************************************
  // Analog output channels
  // ****************************************
  logic [DAC_W-1:0] ch_word [2];
  logic signed [DAC_W:0] ch_value [2];
  logic [1:0] ch_bip;
  logic [1:0] ch_ext;
  for (genvar c = 0; c < 2; c++) begin : g_chan
    bocfg_dac_chan u_chan (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .code_i(dac_code[c]),
      .bipolar_i(ao_cfg[c*AO_CH_STRIDE + AO_BIPOLAR_BIT]),
      .ext_ref_i(ao_cfg[c*AO_CH_STRIDE + AO_EXT_REF_BIT]),
      .word_o(ch_word[c]),
      .value_o(ch_value[c]),
      .bipolar_o(ch_bip[c]),
      .ext_ref_o(ch_ext[c])
    );
  end

  assign dac0_word_o = ch_word[0];
  assign dac0_value_o = ch_value[0];
  assign dac0_bipolar_o = ch_bip[0];
  assign dac0_ext_ref_o = ch_ext[0];
  assign dac1_word_o = ch_word[1];
  assign dac1_value_o = ch_value[1];
  assign dac1_bipolar_o = ch_bip[1];
  assign dac1_ext_ref_o = ch_ext[1];

  // ****************************************
  // Digital ports
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dio_a_oe_o <= '0; // R7
      dio_b_oe_o <= '0; // R7
      dio_a_o <= '0;
      dio_b_o <= '0;
    end else begin
      dio_a_oe_o <= {DIO_W{dio_dir[DIO_A_OUT_BIT]}}; // R5 R6
      dio_b_oe_o <= {DIO_W{dio_dir[DIO_B_OUT_BIT]}}; // R5 R6
      dio_a_o <= dio_data[DIO_A_LSB +: DIO_W];
      dio_b_o <= dio_data[DIO_B_LSB +: DIO_W];
    end
  end

  // ****************************************
  // Timebase
  // ****************************************
  logic osc_tick;
  logic osc_level;
  logic bus_edge;
  logic sel_tick;
  bocfg_divider #(.N(OSC_DIV_CYC)) u_osc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(1'b1),
    .tick_o(osc_tick),
    .level_o(osc_level)
  );

  assign bus_edge = bus_s2 && !bus_s3;
  assign sel_tick = clk_cfg[CLK_BUS_SRC_BIT] ? bus_edge : osc_tick; // R8

  bocfg_divider #(.N(CTR_SRC_DIV)) u_ctr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(sel_tick),
    .tick_o(ctr_src_tick_o), // R10
    .level_o(ctr_src_clk_o)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      board_sync_bus_clk_o <= 1'b0;
      board_sync_bus_clk_oe_o <= 1'b0; // R11
    end else begin
      board_sync_bus_clk_o <= osc_level;
      board_sync_bus_clk_oe_o <= clk_cfg[CLK_DRIVE_BIT] && !clk_cfg[CLK_BUS_SRC_BIT]; // R9 R12
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  logic [3:0] h_src_cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      h_src_cnt <= 4'h0;
    end else if (ctr_src_tick_o) begin
      h_src_cnt <= sel_tick ? 4'h1 : 4'h0;
    end else if (sel_tick) begin
      h_src_cnt <= 4'(h_src_cnt + 1'b1);
    end
  end
  sequence s_osc_gap;
    !osc_tick [*3] ##1 osc_tick;
  endsequence
  property p_ref_sel;
    @(posedge clk_i) disable iff (rst_i)
      ##1 dac1_ext_ref_o == $past(ao_cfg[AO_CH_STRIDE + AO_EXT_REF_BIT]);
  endproperty
  a_ref_sel: assert property (p_ref_sel) else $error("channel 1 reference wrong"); // R1
  property p_bipolar_code;
    @(posedge clk_i) disable iff (rst_i)
      ao_cfg[AO_BIPOLAR_BIT] |=> dac0_word_o == {~$past(dac_code[0][11]), $past(dac_code[0][10:0])}
        && dac0_value_o[DAC_W] == $past(dac_code[0][11]);
  endproperty
  a_bipolar_code: assert property (p_bipolar_code) else $error("bipolar code wrong"); // R3
  property p_unipolar_code;
    @(posedge clk_i) disable iff (rst_i)
      !ao_cfg[AO_BIPOLAR_BIT] |=> dac0_word_o == $past(dac_code[0]) && !dac0_value_o[DAC_W];
  endproperty
  a_unipolar_code: assert property (p_unipolar_code) else $error("unipolar code wrong"); // R4
  property p_dir_ports;
    @(posedge clk_i) disable iff (rst_i)
      ##1 dio_a_oe_o == {DIO_W{$past(dio_dir[0])}} && dio_b_oe_o == {DIO_W{$past(dio_dir[1])}};
  endproperty
  a_dir_ports: assert property (p_dir_ports) else $error("port direction wrong"); // R6
  property p_dio_reset;
    @(posedge clk_i) rst_i |=> dio_a_oe_o == '0 && dio_b_oe_o == '0;
  endproperty
  a_dio_reset: assert property (p_dio_reset) else $error("ports not input after reset"); // R7
  property p_osc_rate;
    @(posedge clk_i) disable iff (rst_i) osc_tick |=> s_osc_gap;
  endproperty
  a_osc_rate: assert property (p_osc_rate) else $error("oscillator rate wrong"); // R8
  property p_drive_gate;
    @(posedge clk_i) disable iff (rst_i)
      board_sync_bus_clk_oe_o |-> $past(clk_cfg) == 2'b10;
  endproperty
  a_drive_gate: assert property (p_drive_gate) else $error("bus driven when not allowed"); // R9
  property p_div10;
    @(posedge clk_i) disable iff (rst_i) ctr_src_tick_o |-> h_src_cnt == 4'hA;
  endproperty
  a_div10: assert property (p_div10) else $error("counter source not divide by ten"); // R10
  property p_clk_default;
    @(posedge clk_i) rst_i |=> !board_sync_bus_clk_oe_o && clk_cfg == 2'b00;
  endproperty
  a_clk_default: assert property (p_clk_default) else $error("clock default wrong"); // R11
  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
endmodule : bocfg_top

// ---- bocfg_sync_peer.sv ----
// Model of another board sharing the synchronization bus clock line
`timescale 1ns/100ps
module bocfg_sync_peer #(
  parameter int HALF = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Drive request from the bench
  input wire logic drive_i,
  // Line as this board sees it
  output logic clk_o
);
  int cnt;

  // ****************************************
  // Bus clock or released line
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 0;
      clk_o <= 1'b0;
    end else if (drive_i) begin
      if (cnt == HALF - 1) begin
        cnt <= 0;
        clk_o <= ~clk_o;
      end else begin
        cnt <= cnt + 1;
      end
    end else begin
      cnt <= 0;
      clk_o <= 1'b1;
    end
  end
endmodule : bocfg_sync_peer

// ---- bocfg_top_tb_top.sv ----
// Self-checking testbench of the board output and timebase configuration block
`timescale 1ns/100ps
module bocfg_top_tb_top import bocfg_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat_w = 32'h0;
  logic [31:0] dat_r, rd;
  logic ack, b0, b1, e0, e1, sb_o, sb_oe, peer_clk, tick, sq;
  logic [11:0] w0, w1;
  logic signed [12:0] v0, v1;
  logic [3:0] pa = 4'h0;
  logic [3:0] pb = 4'h0;
  logic [3:0] ao, bo, aoe, boe;
  logic peer_en = 1'b0;
  logic [3:0] sel = 4'hF;
  logic [3:0] lanes = 4'hF;
  logic [15:0] lfsr = 16'h0063;
  int n_fail = 0;
  int checks_done = 0;
  int cfg_m, dir_m, clk_m, dat_m;
  int code_m[2];
  int bnd[4] = '{32'h0, 32'h7FF, 32'h800, 32'hFFF};
  wire sb_wire = sb_oe ? sb_o : peer_clk;

  always #12.5 clk = ~clk;

  bocfg_top u_bocfg_top (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
    .wb_ack_o(ack), .dac0_word_o(w0), .dac0_value_o(v0), .dac0_bipolar_o(b0),
    .dac0_ext_ref_o(e0), .dac1_word_o(w1), .dac1_value_o(v1), .dac1_bipolar_o(b1),
    .dac1_ext_ref_o(e1), .dio_a_i(pa), .dio_a_o(ao), .dio_a_oe_o(aoe), .dio_b_i(pb),
    .dio_b_o(bo), .dio_b_oe_o(boe), .board_sync_bus_clk_i(sb_wire),
    .board_sync_bus_clk_o(sb_o), .board_sync_bus_clk_oe_o(sb_oe),
    .ctr_src_tick_o(tick), .ctr_src_clk_o(sq));

  bocfg_sync_peer #(.HALF(4)) u_bocfg_sync_peer (.clk_i(clk), .rst_i(rst),
    .drive_i(peer_en), .clk_o(peer_clk));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return {16'h0000, lfsr};
  endfunction : rnd

  function automatic logic pick(input int s);
    return (s == 2) ? sq : (s == 1) ? sb_o : tick;
  endfunction : pick

  function automatic logic [31:0] exp_word(input int c, input bit b);
    return b ? (c ^ 32'h800) : c;
  endfunction : exp_word

  function automatic logic [31:0] exp_val(input int c, input bit b);
    return (b && c >= 2048) ? c - 4096 : c;
  endfunction : exp_val

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= lanes;
    adr <= a;
    dat_w <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 16) check("ack", 32'h0, 32'h1);
  endtask : wb

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    cfg_m = 0;
    dir_m = 0;
    clk_m = 0;
    dat_m = 0;
    code_m = '{0, 0};
  endtask : do_reset

  task automatic check_outs();
    idle(2);
    check("dac0_word", w0, exp_word(code_m[0], cfg_m[1]));
    check("dac0_value", v0, exp_val(code_m[0], cfg_m[1]));
    check("dac1_word", w1, exp_word(code_m[1], cfg_m[3]));
    check("dac1_value", v1, exp_val(code_m[1], cfg_m[3]));
    check("ao_flags", {28'h0, b1, e1, b0, e0}, cfg_m[3:0]);
    check("dio_oe", {24'h0, boe, aoe}, {24'h0, {4{dir_m[1]}}, {4{dir_m[0]}}});
    check("dio_out", {24'h0, bo, ao}, dat_m[7:0]);
    check("sync_oe", sb_oe, clk_m == 2);
  endtask : check_outs

  // Period in clocks between rising edges of the tick, bus clock or counter source level
  task automatic gap(input string nm, input int sb, input int exp);
    int n;
    logic p;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        p = pick(sb);
        @(posedge clk);
        n++;
      end while (!(p === 1'b0 && pick(sb) === 1'b1) && n < 400);
    end
    check(nm, n, exp);
  endtask : gap

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    idle(20000);
    n_fail++;
    stop_test();
  end

  initial begin
    do_reset();
    check_outs();
    for (int a = 0; a < 6; a++) begin
      wb(1'b0, 8'(a * 4), 32'h0);
      check("reset_read", rd, 32'h0);
    end
    wb(1'b0, REG_STATUS, 32'h0);
    check("status_rst", rd & 32'h3, 32'h0);
    $display("test reset_defaults done");
    for (int i = 0; i < 16; i++) begin
      cfg_m = i;
      code_m[0] = bnd[i / 4];
      code_m[1] = rnd() & 32'hFFF;
      wb(1'b1, REG_AO_CFG, (rnd() << 8) | i);
      wb(1'b1, REG_DAC0_CODE, (rnd() << 16) | code_m[0]);
      wb(1'b1, REG_DAC1_CODE, (rnd() << 16) | code_m[1]);
      check_outs();
      wb(1'b0, REG_AO_CFG, 32'h0);
      check("ao_cfg_rd", rd, i);
      wb(1'b0, REG_DAC0_CODE, 32'h0);
      check("dac0_rd", rd, code_m[0]);
    end
    lanes = 4'h2;
    code_m[1] = (code_m[1] & 32'h0FF) | 32'h500;
    wb(1'b1, REG_DAC1_CODE, 32'hFFFF05AA);
    lanes = 4'h0;
    wb(1'b1, REG_AO_CFG, 32'h0);
    lanes = 4'hF;
    check_outs();
    wb(1'b0, REG_DAC1_CODE, 32'h0);
    check("dac1_lane_rd", rd, code_m[1]);
    $display("test analog_output done");
    for (int d = 0; d < 4; d++) begin
      dir_m = d;
      dat_m = rnd() & 32'hFF;
      @(posedge clk);
      pa <= 4'(rnd());
      pb <= 4'(rnd());
      wb(1'b1, REG_DIO_DIR, (rnd() << 4) | d);
      wb(1'b1, REG_DIO_DATA, dat_m);
      wb(1'b1, 8'hFC, 32'hFFFFFFFF);
      check_outs();
      wb(1'b0, REG_DIO_DATA, 32'h0);
      check("dio_in", rd, {24'h0, pb, pa});
      wb(1'b0, 8'hFC, 32'h0);
      check("unmapped_rd", rd, 32'h0);
      wb(1'b0, REG_DIO_DIR, 32'h0);
      check("dio_dir_rd", rd, d);
    end
    $display("test digital_ports done");
    gap("tick_internal", 0, 40);
    gap("ctr_clk_internal", 2, 40);
    clk_m = 2;
    wb(1'b1, REG_CLK_CFG, 32'h2);
    check_outs();
    gap("bus_out_period", 1'b1, 4);
    wb(1'b0, REG_STATUS, 32'h0);
    check("status_drive", rd & 32'h3, 32'h2);
    clk_m = 3;
    wb(1'b1, REG_CLK_CFG, 32'h3);
    check_outs();
    peer_en <= 1'b1;
    gap("tick_bus_drv", 1'b0, 80);
    wb(1'b0, REG_STATUS, 32'h0);
    check("status_src", rd & 32'h3, 32'h1);
    clk_m = 1;
    wb(1'b1, REG_CLK_CFG, 32'h1);
    check_outs();
    gap("tick_bus", 1'b0, 80);
    $display("test timebase done");
    wb(1'b1, REG_DIO_DIR, 32'h3);
    wb(1'b1, REG_AO_CFG, 32'hF);
    peer_en <= 1'b0;
    do_reset();
    check_outs();
    gap("tick_after_rst", 1'b0, 40);
    $display("test second_reset done");
    stop_test();
  end
endmodule : bocfg_top_tb_top
